// >>> core/flyback_pkg.sv
// Constants, timing counts and carrier types for the flyback PWM controller
package flyback_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_HZ             = 125_000_000;
  localparam int CLK_KHZ            = CLK_HZ / 1000;
  localparam int SW_FREQ_HZ         = 65_000;
  localparam int NOM_PERIOD_CYC     = CLK_HZ / SW_FREQ_HZ;
  localparam int SHUFFLE_PCT        = 4;
  localparam int SHUFFLE_SPAN_CYC   = NOM_PERIOD_CYC * SHUFFLE_PCT / 100;
  localparam int SHUFFLE_PERIOD_MS  = 32;
  localparam int SHUFFLE_STEP_CYC   = SHUFFLE_PERIOD_MS * CLK_KHZ / (4 * SHUFFLE_SPAN_CYC);
  localparam int BURST_FREQ_HZ      = 22_000;
  localparam int MAX_PERIOD_CYC     = CLK_HZ / BURST_FREQ_HZ;
  localparam int FOLD_MAX_CYC       = MAX_PERIOD_CYC - NOM_PERIOD_CYC;
  localparam int BLANK_NS           = 250;
  localparam int BLANK_CYC          = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int MAX_DUTY_PERMILLE  = 667;
  localparam int MAX_ON_CYC         = NOM_PERIOD_CYC * MAX_DUTY_PERMILLE / 1000;
  localparam int SS_MS              = 20;
  localparam int SS_CYC             = SS_MS * CLK_KHZ;
  localparam int OVERLOAD_MS        = 75;
  localparam int OVERLOAD_CYC       = OVERLOAD_MS * CLK_KHZ;

  // ==========================================================================
  // Level scaling (10-bit digitised sense values, full scale 1023)
  localparam int        LVL_W         = 10;
  localparam int        PER_W         = 13;
  localparam int        SS_STEPS      = 1024;
  localparam int        SS_STEP_CYC   = SS_CYC / SS_STEPS;
  localparam logic [9:0] CS_LIMIT_BASE = 10'h2C0;
  localparam logic [9:0] GREEN_FEEDBACK_LVL = 10'h180;
  localparam int        SLOPE_SHIFT   = 3;
  localparam int        DUTY_SHIFT    = 3;
  localparam int        FOLD_GAIN_SH  = 3;
  localparam logic [12:0] FOLD_SLEW    = 13'h0008;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic cv_mode;
    logic feedback_above_limit;
    logic feedback_above_skip;
    logic temp_below_recovery;
    logic temp_above_shutdown;
    logic vdd_above_overvoltage;
    logic vdd_below_off;
    logic vdd_above_on;
  } analog_flags_t;

  localparam int FLAG_W = $bits(analog_flags_t);

  typedef enum logic [1:0] {
    ST_LOCKOUT = 2'b00,
    ST_RUN     = 2'b01,
    ST_FAULT   = 2'b10
  } ctrl_state_t;

endpackage : flyback_pkg

// >>> core/flag_sync.sv
// Two-flop synchroniser bank for the analog comparator flags
`timescale 1ns/1ps
module flag_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  for (genvar i = 0; i < WIDTH; i++) begin : g_sync
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        meta_reg[i] <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        meta_reg[i] <= async_in[i];
        sync_out[i] <= meta_reg[i];
      end
    end
  end

endmodule : flag_sync

// >>> core/switching_osc.sv
// Switching oscillator with frequency shuffling and period extension input
`timescale 1ns/1ps
module switching_osc #(
  parameter int SHUFFLE_STEP = flyback_pkg::SHUFFLE_STEP_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        enable,
  input  wire logic [12:0] period_ext,
  output logic             cycle_start,
  output logic [12:0]      phase
);

  localparam logic [12:0] NOM  = 13'(flyback_pkg::NOM_PERIOD_CYC);
  localparam logic [12:0] SPAN = 13'(flyback_pkg::SHUFFLE_SPAN_CYC);
  localparam logic [23:0] STEP = 24'(SHUFFLE_STEP);

  logic [23:0] step_cnt_reg;
  logic [12:0] shuffle_reg;
  logic        shuffle_up_reg;
  logic [12:0] phase_reg;

  // Shuffle offset sweeps 0..2*SPAN as a triangle; period centres on NOM
  wire        step_tick  = (step_cnt_reg == STEP - 24'h000001);
  wire [12:0] period     = NOM - SPAN + shuffle_reg + period_ext;
  wire        period_end = (phase_reg >= period - 13'h0001);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      step_cnt_reg   <= 24'h000000;
      shuffle_reg    <= 13'h0000;
      shuffle_up_reg <= 1'b1;
    end else begin
      step_cnt_reg <= step_tick ? 24'h000000 : step_cnt_reg + 24'h000001;
      if (step_tick) begin
        shuffle_reg <= shuffle_up_reg ? shuffle_reg + 13'h0001 : shuffle_reg - 13'h0001;
        if (shuffle_up_reg && shuffle_reg == {SPAN[11:0], 1'b0} - 13'h0001)
          shuffle_up_reg <= 1'b0;
        else if (!shuffle_up_reg && shuffle_reg == 13'h0001)
          shuffle_up_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      phase_reg   <= 13'h0000;
      cycle_start <= 1'b0;
    end else begin
      phase_reg   <= (!enable || period_end) ? 13'h0000 : phase_reg + 13'h0001;
      cycle_start <= enable && period_end;
    end
  end

  assign phase = phase_reg;

endmodule : switching_osc

// >>> core/flyback_pwm_protection_ctrl.sv
// Control core of the current-mode flyback switch: start-up, PWM and protection
`timescale 1ns/1ps
module flyback_pwm_protection_ctrl #(
  parameter int SS_STEP_CYCLES      = flyback_pkg::SS_STEP_CYC,
  parameter int OVERLOAD_CYCLES     = flyback_pkg::OVERLOAD_CYC,
  parameter int SHUFFLE_STEP_CYCLES = flyback_pkg::SHUFFLE_STEP_CYC
) (
  input  wire logic                       ref_clk,
  input  wire logic                       reset,
  input  wire flyback_pkg::analog_flags_t flags_in,
  input  wire logic [9:0]                 feedback_input,
  input  wire logic [9:0]                 cs_level,
  output logic                            gate_drive,
  output logic                            op_current_en,
  output logic                            burst_standby,
  output logic                            fault_active,
  output logic                            thermal_shutdown,
  output logic [9:0]                      cycle_current_limit
);

  // ==========================================================================
  // Flag synchronisation
  flyback_pkg::analog_flags_t flags;
  logic [flyback_pkg::FLAG_W-1:0] flags_vec;

  flag_sync #(
    .WIDTH    (flyback_pkg::FLAG_W)
  ) u_flag_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (flags_in),
    .sync_out (flags_vec)
  );

  assign flags = flyback_pkg::analog_flags_t'(flags_vec);

  // Multi-bit levels are registered once; they come from a sampled converter
  logic [9:0] feedback_reg;
  logic [9:0] cs_reg;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      feedback_reg <= 10'h000;
      cs_reg       <= 10'h000;
    end else begin
      feedback_reg <= feedback_input;
      cs_reg <= cs_level;
    end
  end

  // ==========================================================================
  // Protection state
  flyback_pkg::ctrl_state_t state_reg;
  flyback_pkg::ctrl_state_t state_next;
  logic                     otp_reg;
  logic [23:0]              overload_cnt_reg;

  localparam logic [23:0] OVERLOAD_LIMIT = 24'(OVERLOAD_CYCLES);

  // Overload counts only while continuously present in constant-voltage mode
  wire overload_protection = flags.cv_mode && flags.feedback_above_limit;
  wire overload_trip       = (overload_cnt_reg >= OVERLOAD_LIMIT);
  wire supply_overvoltage_protection = flags.vdd_above_overvoltage;

  // Thermal latch with hysteresis: hot sets, only the recovery flag clears
  wire otp_next = flags.temp_above_shutdown ? 1'b1 :
                  (flags.temp_below_recovery ? 1'b0 : otp_reg);

  wire fault_now = supply_overvoltage_protection || overload_trip || otp_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      flyback_pkg::ST_LOCKOUT: begin
        if (flags.vdd_above_on && !otp_reg)
          state_next = flyback_pkg::ST_RUN;
      end
      flyback_pkg::ST_RUN: begin
        if (flags.vdd_below_off)
          state_next = flyback_pkg::ST_LOCKOUT;
        else if (fault_now)
          state_next = flyback_pkg::ST_FAULT;
      end
      flyback_pkg::ST_FAULT: begin
        if (flags.vdd_below_off)
          state_next = flyback_pkg::ST_LOCKOUT;
      end
      default: state_next = flyback_pkg::ST_LOCKOUT;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= flyback_pkg::ST_LOCKOUT;
      otp_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      otp_reg   <= otp_next;
    end
  end

  wire running = (state_reg == flyback_pkg::ST_RUN);

  // Debounce restarts in every lockout so a recurring fault needs the full time
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      overload_cnt_reg <= 24'h000000;
    end else if (!running || !overload_protection) begin
      overload_cnt_reg <= 24'h000000;
    end else if (!overload_trip) begin
      overload_cnt_reg <= overload_cnt_reg + 24'h000001;
    end
  end

  // ==========================================================================
  // Soft start
  localparam logic [21:0] SS_STEP = 22'(SS_STEP_CYCLES);

  logic [21:0] ss_cnt_reg;
  logic [9:0]  ss_level_reg;

  wire ss_tick = (ss_cnt_reg == SS_STEP - 22'h000001);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ss_cnt_reg   <= 22'h000000;
      ss_level_reg <= 10'h000;
    end else if (!running) begin
      ss_cnt_reg   <= 22'h000000;
      ss_level_reg <= 10'h000;
    end else begin
      ss_cnt_reg <= ss_tick ? 22'h000000 : ss_cnt_reg + 22'h000001;
      if (ss_tick && ss_level_reg != 10'h3FF)
        ss_level_reg <= ss_level_reg + 10'h001;
    end
  end

  // ==========================================================================
  // Light-load foldback
  logic [12:0] fold_reg;

  // Extension grows with the distance of feedback below the green level
  wire [9:0]  feedback_deficit = (feedback_reg < flyback_pkg::GREEN_FEEDBACK_LVL) ?
                                 flyback_pkg::GREEN_FEEDBACK_LVL - feedback_reg : 10'h000;
  wire [12:0] fold_raw    = {feedback_deficit, 3'b000};
  wire [12:0] fold_cap    = 13'(flyback_pkg::FOLD_MAX_CYC);
  wire [12:0] fold_target = (fold_raw > fold_cap) ? fold_cap : fold_raw;

  wire        cycle_start;
  wire [12:0] phase;

  // Slewing a few cycles per period keeps the frequency change inaudible
  wire [12:0] fold_up   = (fold_target - fold_reg > flyback_pkg::FOLD_SLEW) ?
                          fold_reg + flyback_pkg::FOLD_SLEW : fold_target;
  wire [12:0] fold_down = (fold_reg - fold_target > flyback_pkg::FOLD_SLEW) ?
                          fold_reg - flyback_pkg::FOLD_SLEW : fold_target;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fold_reg <= 13'h0000;
    end else if (cycle_start) begin
      fold_reg <= (fold_target > fold_reg) ? fold_up : fold_down;
    end
  end

  switching_osc #(
    .SHUFFLE_STEP (SHUFFLE_STEP_CYCLES)
  ) u_osc (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .enable      (running),
    .period_ext  (fold_reg),
    .cycle_start (cycle_start),
    .phase       (phase)
  );

  // ==========================================================================
  // PWM and current limit
  logic [12:0] on_time_reg;
  logic [9:0]  limit_reg;

  localparam logic [12:0] BLANK_END = 13'(flyback_pkg::BLANK_CYC);
  localparam logic [12:0] MAX_ON  = 13'(flyback_pkg::MAX_ON_CYC);

  // Longer on-time (low line) earns a higher peak limit for flat output power
  wire [10:0] duty_sum   = {1'b0, flyback_pkg::CS_LIMIT_BASE} +
                           {1'b0, on_time_reg[12:3]};
  wire [9:0]  duty_limit = duty_sum[10] ? 10'h3FF : duty_sum[9:0];
  wire [9:0]  eff_limit  = (ss_level_reg < duty_limit) ? ss_level_reg : duty_limit;

  // Compensation ramp rises with time into the on-pulse
  wire [10:0] slope      = {1'b0, phase[12:3]};
  wire [10:0] cs_sum     = {1'b0, cs_reg} + slope;
  wire [9:0]  feedback_demand = {1'b0, feedback_reg[9:1]};
  wire        pwm_trip   = (cs_sum >= {1'b0, feedback_demand}) ||
                           (cs_sum >= {1'b0, limit_reg});
  wire        blanked    = (phase < BLANK_END);
  wire        gate_off   = (pwm_trip && !blanked) || (phase >= MAX_ON);

  // Switching only starts a new pulse when nothing holds the gate off
  wire        gate_allow = running && !fault_now && flags.feedback_above_skip;
  wire        gate_next  = !gate_allow ? 1'b0 :
                           (cycle_start ? 1'b1 : (gate_off ? 1'b0 : gate_drive));

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      gate_drive  <= 1'b0;
      on_time_reg <= 13'h0000;
      limit_reg   <= 10'h000;
    end else begin
      gate_drive <= gate_next;
      limit_reg  <= eff_limit;
      if (gate_drive && !gate_next)
        on_time_reg <= phase;
    end
  end

  // ==========================================================================
  // Status outputs
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      op_current_en       <= 1'b0;
      burst_standby       <= 1'b0;
      fault_active        <= 1'b0;
      thermal_shutdown    <= 1'b0;
      cycle_current_limit <= 10'h000;
    end else begin
      op_current_en       <= running;
      burst_standby       <= running && !flags.feedback_above_skip;
      fault_active        <= (state_reg == flyback_pkg::ST_FAULT);
      thermal_shutdown    <= otp_reg;
      cycle_current_limit <= limit_reg;
    end
  end

endmodule : flyback_pwm_protection_ctrl

// >>> sim/flyback_pwm_protection_ctrl_assertions.sv
// Port-level concurrent checks for the flyback control core
`timescale 1ns/1ps
module flyback_ctrl_checker #(
  parameter int SS_STEP_CYCLES      = 2,
  parameter int OVERLOAD_CYCLES     = 50,
  parameter int SHUFFLE_STEP_CYCLES = 4
) (
  input wire logic                       ref_clk,
  input wire logic                       reset,
  input wire flyback_pkg::analog_flags_t flags_in,
  input wire logic [9:0]                 feedback_input,
  input wire logic [9:0]                 cs_level,
  input wire logic                       gate_drive,
  input wire logic                       op_current_en,
  input wire logic                       burst_standby,
  input wire logic                       fault_active,
  input wire logic                       thermal_shutdown,
  input wire logic [9:0]                 cycle_current_limit
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ==========================================
  // Helper counters
  logic [12:0] on_cnt_reg;
  logic [23:0] ovl_cnt_reg;
  wire         ovl_now = flags_in.cv_mode && flags_in.feedback_above_limit && op_current_en;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      on_cnt_reg  <= 13'h0000;
      ovl_cnt_reg <= 24'h000000;
    end else begin
      on_cnt_reg  <= gate_drive ? on_cnt_reg + 13'h0001 : 13'h0000;
      ovl_cnt_reg <= ovl_now ? ovl_cnt_reg + 24'h000001 : 24'h000000;
    end
  end
  // ==========================================
  // Sequences and assertions
  sequence s_idle4;
    !op_current_en [*4];
  endsequence
  sequence s_skip_low;
    !flags_in.feedback_above_skip [*5];
  endsequence
  chk_gate_idle_off: assert property (!op_current_en [*2] |-> !gate_drive)
    else $error("gate on while not running");
  chk_fault_gate_off: assert property (fault_active [*2] |-> !gate_drive)
    else $error("gate on during fault stop");
  chk_skip_gate_off: assert property (s_skip_low |-> !gate_drive && (burst_standby || !op_current_en))
    else $error("switching below skip level");
  chk_ovp_stop: assert property (flags_in.vdd_above_overvoltage [*6] |-> !gate_drive && !op_current_en)
    else $error("no stop on supply overvoltage");
  chk_blank_width: assert property ($fell(gate_drive) && op_current_en && !fault_active && !burst_standby && $past(flags_in, 4) == flags_in |-> on_cnt_reg >= flyback_pkg::BLANK_CYC - 1)
    else $error("pulse ended inside blanking");
  chk_limit_idle_zero: assert property (s_idle4 and !fault_active [*4] |-> cycle_current_limit == 10'h000)
    else $error("limit not cleared while idle");
  chk_soft_start_slew: assert property (op_current_en && $past(op_current_en) && $past(cycle_current_limit) < flyback_pkg::CS_LIMIT_BASE |-> cycle_current_limit <= $past(cycle_current_limit) + 10'h001)
    else $error("limit jumped during soft start");
  chk_start_after_sync: assert property ($rose(op_current_en) |-> $past(flags_in.vdd_above_on, 3))
    else $error("start not three edges after turn-on flag");
  chk_fault_exit_off: assert property ($fell(fault_active) |-> $past(flags_in.vdd_below_off, 2) || $past(flags_in.vdd_below_off, 3))
    else $error("fault cleared without turn-off level");
  chk_overload_debounce: assert property ($rose(fault_active) && !flags_in.vdd_above_overvoltage && !thermal_shutdown |-> ovl_cnt_reg >= OVERLOAD_CYCLES - 2)
    else $error("overload tripped before debounce");
endmodule : flyback_ctrl_checker

bind flyback_pwm_protection_ctrl flyback_ctrl_checker #(
  .SS_STEP_CYCLES(SS_STEP_CYCLES), .OVERLOAD_CYCLES(OVERLOAD_CYCLES),
  .SHUFFLE_STEP_CYCLES(SHUFFLE_STEP_CYCLES)
) chk_u (
  .ref_clk(ref_clk), .reset(reset), .flags_in(flags_in), .feedback_input(feedback_input),
  .cs_level(cs_level), .gate_drive(gate_drive), .op_current_en(op_current_en),
  .burst_standby(burst_standby), .fault_active(fault_active),
  .thermal_shutdown(thermal_shutdown), .cycle_current_limit(cycle_current_limit)
);

// >>> sim/sense_frontend_model.sv
// Behavioural current-sense front end: switch current seen only while the gate is on
`timescale 1ns/1ps
module sense_frontend_model (
  input  wire logic       ref_clk,
  input  wire logic       gate_drive,
  input  wire logic [9:0] cs_base,
  output logic      [9:0] cs_level
);
  initial cs_level = 10'h000;
  // Updated off the sampling edge; a flat level makes on-time depend on the ramp alone
  always @(negedge ref_clk) begin
    cs_level <= gate_drive ? cs_base : 10'h000;
  end
endmodule : sense_frontend_model

// >>> sim/flyback_pwm_protection_ctrl_test.sv
// Self-checking bench for the flyback control core
`timescale 1ns/1ps
module flyback_pwm_protection_ctrl_test;
  localparam int SS_STEP = 2;
  localparam int OVLD    = 50;
  localparam int SHUF    = 40;
  localparam int NOM     = flyback_pkg::NOM_PERIOD_CYC;
  localparam int SPAN    = flyback_pkg::SHUFFLE_SPAN_CYC;
  logic                       ref_clk         = 1'b0;
  logic                       reset           = 1'b1;
  flyback_pkg::analog_flags_t flags_in        = '0;
  logic [9:0]                 feedback_input  = 10'h300;
  logic [9:0]                 cs_base         = 10'h3FF;
  logic [9:0]                 cs_level;
  logic                       gate_drive;
  logic                       op_current_en;
  logic                       burst_standby;
  logic                       fault_active;
  logic                       thermal_shutdown;
  logic [9:0]                 cycle_current_limit;
  int                         err_count       = 0;
  int                         samples_checked = 0;
  int                         cyc             = 0;
  int                         t_on, lo, hi, st, last, n;

  flyback_pwm_protection_ctrl #(.SS_STEP_CYCLES(SS_STEP), .OVERLOAD_CYCLES(OVLD),
    .SHUFFLE_STEP_CYCLES(SHUF)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .flags_in(flags_in), .feedback_input(feedback_input),
    .cs_level(cs_level), .gate_drive(gate_drive), .op_current_en(op_current_en),
    .burst_standby(burst_standby), .fault_active(fault_active),
    .thermal_shutdown(thermal_shutdown), .cycle_current_limit(cycle_current_limit));
  sense_frontend_model sense_u (.ref_clk(ref_clk), .gate_drive(gate_drive),
    .cs_base(cs_base), .cs_level(cs_level));

  initial forever #4 ref_clk = ~ref_clk;
  // ==========================================
  // Shared tasks
  task automatic stop_test();
    $display("errors %0d, comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 100000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic check(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : tick
  task automatic wait_gate(input logic v, input int lim, output int k);
    k = 0;
    while (gate_drive !== v && k < lim) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
  endtask : wait_gate
  // Gate periods over k pulses; t_on keeps the last on-time
  task automatic periods(input int k);
    int a, b, prev;
    lo = 99999; hi = 0; st = 0; prev = 0;
    wait_gate(1'b1, 8000, a);
    for (int i = 0; i < k; i++) begin
      wait_gate(1'b0, 2000, a);
      wait_gate(1'b1, 8000, b);
      t_on = a;
      last = a + b;
      if (last < lo) lo = last;
      if (last > hi) hi = last;
      if (i > 0 && (last - prev > st || prev - last > st)) st = (last > prev) ? last - prev : prev - last;
      prev = last;
    end
    tick(1);
  endtask : periods
  task automatic power_cycle();
    flags_in.vdd_above_on = 1'b0;
    flags_in.vdd_below_off = 1'b1;
    tick(8);
    flags_in.vdd_below_off = 1'b0;
    flags_in.vdd_above_on = 1'b1;
    tick(8);
  endtask : power_cycle
  // ==========================================
  // Scenarios
  task automatic t_start();
    flags_in.feedback_above_skip = 1'b1;
    flags_in.vdd_above_on = 1'b1;
    tick(2);
    check(op_current_en === 1'b0, "started before flag sync");
    tick(4);
    check(op_current_en === 1'b1, "no start at turn-on");
    tick(100);
    check(cycle_current_limit >= 10'(100 / SS_STEP - 8) && cycle_current_limit <= 10'(100 / SS_STEP + 1), "soft start ramp");
    wait_gate(1'b1, NOM + SPAN, n);
    check(n < NOM + SPAN, "first pulse late");
  endtask : t_start
  task automatic t_osc();
    periods(6);
    check(lo >= NOM - SPAN - 2 && hi <= NOM + SPAN + 2, "period out of range");
    check(hi - lo > 4, "no shuffling");
    check(t_on >= flyback_pkg::BLANK_CYC - 1 && t_on <= flyback_pkg::BLANK_CYC + 3, "blanking width");
    check(cycle_current_limit >= 10'(704 + t_on / 8 - 1) && cycle_current_limit <= 10'(704 + t_on / 8 + 1), "duty limit");
  endtask : t_osc
  task automatic t_slope();
    cs_base = 10'h12C;
    periods(2);
    check(t_on >= 8 * (384 - 300) - 6 && t_on <= 8 * (384 - 300) + 6, "slope ramp on-time");
    check(cycle_current_limit >= 10'(704 + t_on / 8 - 2) && cycle_current_limit <= 10'(704 + t_on / 8 + 2), "duty limit long pulse");
    cs_base = 10'h3FF;
  endtask : t_slope
  task automatic t_fold();
    feedback_input = 10'h170;
    periods(17);
    check(st <= 2000 / SHUF + 16, "foldback stepped");
    check(last > NOM + 128 - SPAN - 8, "no foldback");
    feedback_input = 10'h300;
  endtask : t_fold
  task automatic t_burst();
    flags_in.feedback_above_skip = 1'b0;
    tick(6);
    check(burst_standby === 1'b1, "no burst standby");
    wait_gate(1'b1, 4000, n);
    check(n == 4000, "pulse in skip");
    flags_in.feedback_above_skip = 1'b1;
    wait_gate(1'b1, 8000, n);
    check(n < 8000 && burst_standby === 1'b0, "no resume above skip");
  endtask : t_burst
  task automatic t_ovp();
    flags_in.vdd_above_overvoltage = 1'b1;
    tick(6);
    check(fault_active === 1'b1 && op_current_en === 1'b0, "no overvoltage stop");
    flags_in.vdd_above_overvoltage = 1'b0;
    tick(20);
    check(fault_active === 1'b1, "fault left before turn-off");
    power_cycle();
    check(fault_active === 1'b0 && op_current_en === 1'b1, "no restart");
    check(cycle_current_limit < 10'h010, "no fresh soft start");
  endtask : t_ovp
  task automatic t_olp();
    flags_in.cv_mode = 1'b1;
    flags_in.feedback_above_limit = 1'b1;
    tick(OVLD / 2);
    flags_in.feedback_above_limit = 1'b0;
    tick(10);
    check(fault_active === 1'b0, "short overload tripped");
    flags_in.feedback_above_limit = 1'b1;
    tick(OVLD + 8);
    check(fault_active === 1'b1, "overload not tripped");
    power_cycle();
    check(op_current_en === 1'b1, "no restart with fault");
    tick(OVLD + 8);
    check(fault_active === 1'b1, "persisting fault not repeated");
    flags_in.feedback_above_limit = 1'b0;
    power_cycle();
    tick(3 * OVLD);
    check(fault_active === 1'b0 && op_current_en === 1'b1, "no normal run");
  endtask : t_olp
  task automatic t_hot();
    flags_in.temp_above_shutdown = 1'b1;
    tick(6);
    check(thermal_shutdown === 1'b1 && op_current_en === 1'b0 && gate_drive === 1'b0, "no shutdown");
    flags_in.temp_above_shutdown = 1'b0;
    power_cycle();
    check(op_current_en === 1'b0, "restart while hot");
    flags_in.temp_below_recovery = 1'b1;
    tick(8);
    check(thermal_shutdown === 1'b0 && op_current_en === 1'b1, "no restart after cooling");
    check(cycle_current_limit < 10'h010, "no fresh soft start");
    flags_in.temp_below_recovery = 1'b0;
  endtask : t_hot
  initial begin
    tick(16);
    reset = 1'b0;
    t_start();
    t_osc();
    t_slope();
    t_fold();
    t_burst();
    t_ovp();
    t_olp();
    t_hot();
    stop_test();
  end
endmodule : flyback_pwm_protection_ctrl_test
